// [dtcw_pkg.sv]
package dtcw_pkg;

	// detector array and arithmetic widths
	localparam int NUM_DET    = 52;
	localparam int FLUX_W     = 16;
	localparam int SUM_W      = 22;
	localparam int IDX_W      = 6;

	// timing, core clock 20 MHz
	localparam int CLK_PER_NS     = 50;
	localparam int WD_TIMEOUT_US  = 10000;
	localparam int WD_CYC         = WD_TIMEOUT_US * 1000 / CLK_PER_NS;
	localparam int LNK_GAP_US     = 100;
	localparam int LNK_GAP_CYC    = LNK_GAP_US * 1000 / CLK_PER_NS;
	localparam int GAP_W          = 16;

	// rod block monitor frame: fixed length, fixed header
	localparam int          RBM_LEN = 4;
	localparam logic [7:0]  RBM_HDR = 8'h5a;

	// register byte addresses
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_STAT    = 8'h04;
	localparam logic [7:0] A_WDCNT   = 8'h08;
	localparam logic [7:0] A_CAL_IN  = 8'h0c;
	localparam logic [7:0] A_CAL_ACC = 8'h10;
	localparam logic [7:0] A_ERRCNT  = 8'h14;
	localparam logic [7:0] A_THR0    = 8'h20;

	// control bit positions
	localparam int CTRL_BYP   = 0;
	localparam int CTRL_INOP  = 1;
	localparam int CTRL_STALL = 2;
	localparam int CTRL_KICK  = 3;

	// calibration word layout
	localparam logic [7:0] CAL_TAG     = 8'hc5;
	localparam int         CAL_TAG_LSB = 24;
	localparam int         CAL_IDX_LSB = 16;
	localparam int         CAL_ITEMS   = 3;

	// threshold reset values: apm, osc, srm
	localparam logic [15:0] RST_THR_APM = 16'hc000;
	localparam logic [15:0] RST_THR_OSC = 16'h0800;
	localparam logic [15:0] RST_THR_SRM = 16'he000;

	// oscillation arming and short period detection
	localparam logic [15:0] OSC_FLOW_ARM = 16'h6000;
	localparam int          PER_SHIFT    = 3;

	typedef struct packed {
		logic              valid;
		logic              sof;
		logic [FLUX_W-1:0] data;
	} dtcw_lnk_t;

	typedef struct packed {
		logic apm;
		logic osc;
		logic srm;
	} dtcw_vote_t;

	typedef enum logic [2:0] {
		S_IDLE, S_RECV, S_APM, S_OSC, S_SRM, S_SEND
	} dtcw_state_t;

endpackage

// [dtcw_division.sv]
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

// Contract
// - each stage waits idle until data arrives, then processes it
// - stage hands results onward only after finishing its own work
// - watchdog restarts from zero when the whole chain has handed off
// - a stage that never hands off blocks later stages and the restart
// - watchdog expiry marks module failed, trips outputs, raises alarm
// - watchdog restart and timeout can be forced and observed by test
// - all state changes on the common clock edge only
// - link messages have fixed length, format and send point
// - link receiver checks data and timeout, alarms every error
// - link communication failure asserts module failure seen by operator
// - no interrupts, scheduling or variable timing anywhere
// - division takes 52 hardwired local flux detector readings
// - detector readings arrive as fixed sets over a one-way link
// - average power trip drives a discrete vote-to-trip output
// - oscillation monitor uses local power and flow, votes on instability
// - startup monitor votes on high flux or short period
// - calibration input blocked unless bypassed, inoperative and key enabled
// - calibration accepts only limited fixed format, rejects anything else
// - calibration item used only after individual operator acceptance
// - no path to any other division; voting is external
// - one-way fixed sets to rod block monitor, no receive path
// - bypassing average power monitor also bypasses oscillation monitor
module dtcw_division
	import dtcw_pkg::*;
#(
	parameter int WD_TO_CYC = WD_CYC
) (
	// clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_srst,
	// register port
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	// detector module link, same clock
	input  wire dtcw_lnk_t         i_lnk,
	// plant inputs, same clock
	input  wire logic [FLUX_W-1:0] i_core_flow,
	input  wire logic [FLUX_W-1:0] i_srm_flux,
	// key lock pin, asynchronous
	input  wire logic              i_keylock,
	// discrete trip votes and status, no division inputs
	output dtcw_vote_t             o_vote,
	output logic                   o_failed,
	output logic                   o_tripped,
	output logic                   o_alarm,
	// rod block monitor link, transmit only
	output logic                   o_rbm_valid,
	output logic      [31:0]       o_rbm_data
);

	dtcw_state_t                      st_q, st_d;
	logic [IDX_W-1:0]                 idx_q, idx_d;
	logic [SUM_W-1:0]                 sum_q, sum_d, psum_q, psum_d;
	logic [FLUX_W-1:0]                csum_q, csum_d, psrm_q, psrm_d;
	logic [GAP_W-1:0]                 gap_q, gap_d;
	dtcw_vote_t                       trip_q, trip_d, vote_q, vote_d;
	logic [31:0]                      wd_q, wd_d, rbm_q, rbm_d;
	logic                             rv_q, rv_d;
	logic                             failed_q, failed_d;
	logic [7:0]                       err_q, err_d;
	logic                             lerr, pass_done, wd_exp, wd_kick;
	logic [SUM_W-1:0]                 apm_lim, osc_lim, dsum;
	logic [2:0]                       ctrl_q, ctrl_d;
	logic [CAL_ITEMS-1:0][FLUX_W-1:0] thr_q, thr_d;
	logic                             pend_q, pend_d, rej_q, rej_d;
	logic [3:0]                       pidx_q, pidx_d;
	logic [FLUX_W-1:0]                pval_q, pval_d;
	logic [31:0]                      rdata_q, rdata_d;
	logic                             key_m_q, key_q, gate;
	logic                             wr_cal, wr_acc, cal_ok;
	default clocking dcb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);

	assign apm_lim = SUM_W'(thr_q[0]) * SUM_W'(NUM_DET);
	assign osc_lim = SUM_W'(thr_q[1]) * SUM_W'(NUM_DET);
	assign dsum    = (sum_q > psum_q) ? sum_q - psum_q : psum_q - sum_q;
	assign wd_exp  = (wd_q >= 32'(WD_TO_CYC - 1));
	assign wd_kick = i_wr && (i_addr == A_CTRL) && i_wdata[CTRL_KICK];

	// fixed-cycle chain, link receiver and watchdog
	always_comb begin
		st_d      = st_q;
		idx_d     = idx_q;
		sum_d     = sum_q;
		csum_d    = csum_q;
		gap_d     = gap_q;
		psum_d    = psum_q;
		psrm_d    = psrm_q;
		trip_d    = trip_q;
		rbm_d     = rbm_q;
		rv_d      = 1'b0;
		lerr      = 1'b0;
		pass_done = 1'b0;
		case (st_q)
			S_IDLE: begin
				if (i_lnk.valid) begin
					if (i_lnk.sof) begin
						st_d   = S_RECV;
						idx_d  = IDX_W'(1);
						sum_d  = SUM_W'(i_lnk.data);
						csum_d = i_lnk.data;
						gap_d  = '0;
					end else begin
						lerr = 1'b1;
					end
				end
			end
			S_RECV: begin
				gap_d = gap_q + GAP_W'(1);
				if (i_lnk.valid) begin
					gap_d = '0;
					if (i_lnk.sof) begin
						lerr = 1'b1;
						st_d = S_IDLE;
					end else if (idx_q == IDX_W'(NUM_DET)) begin
						if (i_lnk.data == csum_q) begin
							st_d = S_APM;
						end else begin
							lerr = 1'b1;
							st_d = S_IDLE;
						end
					end else begin
						idx_d  = idx_q + IDX_W'(1);
						sum_d  = sum_q + SUM_W'(i_lnk.data);
						csum_d = csum_q ^ i_lnk.data;
					end
				end else if (gap_q == GAP_W'(LNK_GAP_CYC - 1)) begin
					lerr = 1'b1;
					st_d = S_IDLE;
				end
			end
			// test stall holds the stage, nothing later starts
			S_APM: begin
				if (!ctrl_q[CTRL_STALL]) begin
					trip_d.apm = sum_q > apm_lim;
					st_d       = S_OSC;
				end
			end
			// instability only armed at low flow
			S_OSC: begin
				trip_d.osc = (i_core_flow < OSC_FLOW_ARM) && (dsum > osc_lim);
				psum_d     = sum_q;
				st_d       = S_SRM;
			end
			S_SRM: begin
				trip_d.srm = (i_srm_flux > thr_q[2]) ||
					((i_srm_flux > psrm_q) &&
					((i_srm_flux - psrm_q) > (psrm_q >> PER_SHIFT)));
				psrm_d = i_srm_flux;
				idx_d  = '0;
				st_d   = S_SEND;
			end
			// fixed frame sent only after all stages finish
			S_SEND: begin
				rv_d  = 1'b1;
				idx_d = idx_q + IDX_W'(1);
				case (idx_q[1:0])
					2'd0:    rbm_d = {RBM_HDR, 24'h0};
					2'd1:    rbm_d = {10'h0, sum_q};
					2'd2:    rbm_d = {29'h0, trip_q};
					default: rbm_d = {16'h0, psrm_q};
				endcase
				if (idx_q == IDX_W'(RBM_LEN - 1)) begin
					pass_done = 1'b1;
					st_d      = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	always_comb begin
		if (pass_done || wd_kick) begin
			wd_d = '0;
		end else if (wd_exp) begin
			wd_d = wd_q;
		end else begin
			wd_d = wd_q + 32'h1;
		end
		failed_d = failed_q || wd_exp || lerr;
		err_d    = (lerr && err_q != 8'hff) ? err_q + 8'h1 : err_q;
		// one bypass covers both power votes; failure trips all
		vote_d.apm = failed_q || (trip_q.apm && !ctrl_q[CTRL_BYP]);
		vote_d.osc = failed_q || (trip_q.osc && !ctrl_q[CTRL_BYP]);
		vote_d.srm = failed_q || trip_q.srm;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_q     <= S_IDLE;
			idx_q    <= '0;
			sum_q    <= '0;
			csum_q   <= '0;
			gap_q    <= '0;
			psum_q   <= '0;
			psrm_q   <= '0;
			trip_q   <= '0;
			vote_q   <= '0;
			rbm_q    <= '0;
			rv_q     <= 1'b0;
			wd_q     <= '0;
			failed_q <= 1'b0;
			err_q    <= '0;
		end else begin
			st_q     <= st_d;
			idx_q    <= idx_d;
			sum_q    <= sum_d;
			csum_q   <= csum_d;
			gap_q    <= gap_d;
			psum_q   <= psum_d;
			psrm_q   <= psrm_d;
			trip_q   <= trip_d;
			vote_q   <= vote_d;
			rbm_q    <= rbm_d;
			rv_q     <= rv_d;
			wd_q     <= wd_d;
			failed_q <= failed_d;
			err_q    <= err_d;
		end
	end

	// key lock is a panel switch: synchronise before use
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			key_m_q <= 1'b0;
			key_q   <= 1'b0;
		end else begin
			key_m_q <= i_keylock;
			key_q   <= key_m_q;
		end
	end

	assign gate   = ctrl_q[CTRL_BYP] && ctrl_q[CTRL_INOP] && key_q;
	assign wr_cal = i_wr && (i_addr == A_CAL_IN);
	assign wr_acc = i_wr && (i_addr == A_CAL_ACC);
	// tag, spare bits and item index must all match
	assign cal_ok = gate &&
		(i_wdata[CAL_TAG_LSB +: 8] == CAL_TAG) &&
		(i_wdata[23:20] == 4'h0) &&
		(i_wdata[CAL_IDX_LSB +: 4] < 4'(CAL_ITEMS));

	// register file
	always_comb begin
		ctrl_d  = ctrl_q;
		thr_d   = thr_q;
		pend_d  = pend_q;
		pidx_d  = pidx_q;
		pval_d  = pval_q;
		rej_d   = rej_q;
		rdata_d = 32'h0;
		if (i_wr && i_addr == A_CTRL) begin
			ctrl_d = i_wdata[2:0];
		end
		if (wr_cal) begin
			if (cal_ok) begin
				pend_d = 1'b1;
				pidx_d = i_wdata[CAL_IDX_LSB +: 4];
				pval_d = i_wdata[FLUX_W-1:0];
			end else begin
				rej_d = 1'b1;
			end
		end
		// item takes effect only on matching acceptance
		if (wr_acc && pend_q && gate && i_wdata[3:0] == pidx_q) begin
			thr_d[pidx_q[1:0]] = pval_q;
			pend_d             = 1'b0;
		end
		if (i_rd) begin
			if (i_addr == A_CTRL) begin
				rdata_d = {29'h0, ctrl_q};
			end else if (i_addr == A_STAT) begin
				rdata_d = {21'h0, st_q, rej_q, pend_q, key_q,
					wd_exp, failed_q, vote_q};
			end else if (i_addr == A_WDCNT) begin
				rdata_d = wd_q;
			end else if (i_addr == A_CAL_IN) begin
				rdata_d = {pend_q, 11'h0, pidx_q, pval_q};
			end else if (i_addr == A_ERRCNT) begin
				rdata_d = {24'h0, err_q};
			end else if (i_addr == A_THR0) begin
				rdata_d = {16'h0, thr_q[0]};
			end else if (i_addr == A_THR0 + 8'h04) begin
				rdata_d = {16'h0, thr_q[1]};
			end else if (i_addr == A_THR0 + 8'h08) begin
				rdata_d = {16'h0, thr_q[2]};
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			ctrl_q  <= '0;
			thr_q   <= {RST_THR_SRM, RST_THR_OSC, RST_THR_APM};
			pend_q  <= 1'b0;
			pidx_q  <= '0;
			pval_q  <= '0;
			rej_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			thr_q   <= thr_d;
			pend_q  <= pend_d;
			pidx_q  <= pidx_d;
			pval_q  <= pval_d;
			rej_q   <= rej_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata     = rdata_q;
	assign o_vote      = vote_q;
	assign o_failed    = failed_q;
	assign o_tripped   = failed_q;
	assign o_alarm     = failed_q;
	assign o_rbm_valid = rv_q;
	assign o_rbm_data  = rbm_q;

	property p_idle_wait;
		(st_q == S_IDLE && !i_lnk.valid) |=> (st_q == S_IDLE);
	endproperty
	a_idle_wait: assert property (p_idle_wait)
		else $error("stage left idle without data");
	property p_send_after;
		(st_q == S_SRM) |=> !o_rbm_valid ##1 o_rbm_valid[*4] ##1 !o_rbm_valid;
	endproperty
	a_send_after: assert property (p_send_after)
		else $error("result frame not sent after processing");
	property p_wd_restart;
		(st_q == S_SEND && idx_q == IDX_W'(RBM_LEN - 1)) |=> (wd_q == 32'h0);
	endproperty
	a_wd_restart: assert property (p_wd_restart)
		else $error("watchdog not restarted at end of pass");
	property p_stall_holds;
		(st_q == S_APM && ctrl_q[CTRL_STALL]) |=> (st_q == S_APM) && !o_rbm_valid;
	endproperty
	a_stall_holds: assert property (p_stall_holds)
		else $error("later stage started after stalled stage");
	property p_expire;
		(wd_q == 32'(WD_TO_CYC - 1)) |=> o_failed && o_tripped && o_alarm
			##1 (o_vote == 3'b111);
	endproperty
	a_expire: assert property (p_expire)
		else $error("expiry did not fail and trip the division");
	property p_kick;
		wd_kick |=> (wd_q == 32'h0) ##1 (wd_q == 32'h1 || $past(pass_done));
	endproperty
	a_kick: assert property (p_kick)
		else $error("forced watchdog restart not seen");
	property p_link_fail;
		lerr |=> o_failed && o_alarm && (err_q != 8'h0);
	endproperty
	a_link_fail: assert property (p_link_fail)
		else $error("link error did not mark module failed");
	property p_latch;
		o_failed |=> o_failed;
	endproperty
	a_latch: assert property (p_latch)
		else $error("failed state released without reset");
	property p_cal_block;
		(wr_cal && !gate) |=> rej_q && $stable(thr_q);
	endproperty
	a_cal_block: assert property (p_cal_block)
		else $error("calibration accepted while gate closed");
	property p_cal_accept;
		(thr_q != $past(thr_q)) |-> $past(wr_acc && pend_q);
	endproperty
	a_cal_accept: assert property (p_cal_accept)
		else $error("threshold changed without acceptance");
	property p_bypass;
		(ctrl_q[CTRL_BYP] && !failed_q) |=> !o_vote.apm && !o_vote.osc;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypassed power vote still asserted");
	c_pass: cover property (pass_done);
	c_expire: cover property (wd_exp && !failed_q);
	c_commit: cover property (wr_acc && pend_q && gate);

endmodule

// [dtcw_voter.sv]
`timescale 1ns/1ps

// far-side model: two-out-of-four trip vote across the four divisions
module dtcw_voter (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_srst,
	// tripped state of every division
	input  wire logic [3:0] i_div_trip,
	// scram order
	output logic            o_scram
);
	logic [2:0] cnt;

	always_comb begin
		cnt = 3'h0;
		for (int i = 0; i < 4; i++) begin
			cnt = cnt + {2'h0, i_div_trip[i]};
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_scram <= 1'b0;
		end else begin
			o_scram <= (cnt >= 3'h2);
		end
	end
endmodule

// [division_trip_chain_watchdog_test.sv]
`timescale 1ns/1ps

module division_trip_chain_watchdog_test;
	import dtcw_pkg::*;

	localparam int WDT = 200;

	logic        i_core_clk = 1'b0;
	logic        i_srst     = 1'b1;
	logic [7:0]  i_addr     = 8'h00;
	logic [31:0] i_wdata    = 32'h0;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	dtcw_lnk_t   i_lnk      = '0;
	logic [15:0] i_srm_flux = 16'h0;
	logic [15:0] i_core_flow = 16'hffff;
	logic        i_keylock  = 1'b0;
	logic [2:0]  other_trip = 3'h1;
	logic [31:0] o_rdata;
	dtcw_vote_t  o_vote;
	logic        o_failed;
	logic        o_tripped;
	logic        o_alarm;
	logic        o_rbm_valid;
	logic [31:0] o_rbm_data;
	logic        scram;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          checks    = 0;

	always #25 i_core_clk = ~i_core_clk;

	dtcw_division #(.WD_TO_CYC(WDT)) dut_u (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_addr     (i_addr),
		.i_wdata    (i_wdata),
		.i_wr       (i_wr),
		.i_rd       (i_rd),
		.o_rdata    (o_rdata),
		.i_lnk      (i_lnk),
		.i_core_flow(i_core_flow),
		.i_srm_flux (i_srm_flux),
		.i_keylock  (i_keylock),
		.o_vote     (o_vote),
		.o_failed   (o_failed),
		.o_tripped  (o_tripped),
		.o_alarm    (o_alarm),
		.o_rbm_valid(o_rbm_valid),
		.o_rbm_data (o_rbm_data)
	);

	dtcw_voter voter_u (
		.i_core_clk(i_core_clk),
		.i_srst    (i_srst),
		.i_div_trip({other_trip, o_tripped}),
		.o_scram   (scram)
	);

	task automatic end_sim();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rst();
		@(posedge i_core_clk);
		i_srst <= 1'b1;
		repeat (20) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr    <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge i_core_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd   <= 1'b0;
		#1 rd = o_rdata;
	endtask

	// one frame of equal readings; checksum of an even count is zero
	task automatic send(input logic [15:0] v, input logic bad);
		for (int i = 0; i < 53; i++) begin
			@(posedge i_core_clk);
			i_lnk <= {1'b1, i == 0, (i < 52) ? v : {15'h0, bad}};
		end
		@(posedge i_core_clk);
		i_lnk <= {1'b0, 1'b0, ~v};
	endtask

	// sel high waits for the failed flag, low for a frame word
	task automatic wait_flag(input logic sel, input int n);
		logic f;
		f = 1'b0;
		for (int k = 0; k < n && f !== 1'b1; k++) begin
			@(posedge i_core_clk);
			#1;
			f = sel ? o_failed : o_rbm_valid;
		end
		if (f !== 1'b1) begin
			error_cnt++;
			end_sim();
		end
	endtask

	task automatic pass(input logic [15:0] v, input logic [15:0] fl,
			input logic byp, input logic [2:0] ev);
		logic [31:0] ew [4];
		rst();
		i_srm_flux <= fl;
		wr(A_CTRL, {31'h0, byp});
		ew = '{{RBM_HDR, 24'h0}, {10'h0, 22'(v * 52)},
			{29'h0, ev}, {16'h0, fl}};
		send(v, 1'b0);
		wait_flag(1'b0, 20);
		for (int j = 0; j < 4; j++) begin
			check({o_rbm_valid, o_rbm_data}, {1'b1, ew[j]});
			@(posedge i_core_clk);
			#1;
		end
		check(o_rbm_valid, 1'b0);
		// bypass masks the power votes, not the frame
		check(o_vote, byp ? {2'h0, ev[0]} : ev);
		check(scram, 1'b0);
		rdr(A_WDCNT);
		check(rd < 32'h8, 1'b1);
		i_srm_flux <= 16'h0;
	endtask

	task automatic t_passes();
		pass(16'h0100, 16'h0, 1'b0, 3'h0);
		pass(16'hffff, 16'h0, 1'b1, 3'h4);
		pass(16'hffff, 16'h0, 1'b0, 3'h4);
		pass(16'h0100, 16'hf000, 1'b0, 3'h1);
		i_core_flow <= 16'h1000;
		pass(16'h1000, 16'h0, 1'b0, 3'h2);
		pass(16'h1000, 16'h0, 1'b1, 3'h2);
		i_core_flow <= 16'hffff;
	endtask

	task automatic t_link_err();
		rst();
		send(16'h0100, 1'b1);
		wait_flag(1'b1, 10);
		check({o_alarm, o_tripped}, 2'h3);
		rdr(A_ERRCNT);
		check(rd, 32'h1);
		check(o_rbm_valid, 1'b0);
	endtask

	task automatic t_stall();
		rst();
		wr(A_CTRL, 32'h4);
		send(16'h0100, 1'b0);
		#1;
		check(o_rbm_valid, 1'b0);
		wait_flag(1'b1, WDT + 10);
		@(posedge i_core_clk);
		#1;
		check({o_vote, o_alarm, o_tripped}, 5'h1f);
		check(scram, 1'b1);
		rdr(A_STAT);
		check(rd[10:8], 3'h2);
		check(rd[4], 1'b1);
		wr(A_CTRL, 32'h8);
		repeat (3) @(posedge i_core_clk);
		#1;
		check(o_failed, 1'b1);
	endtask

	task automatic t_kick();
		rst();
		repeat (WDT - 20) @(posedge i_core_clk);
		wr(A_CTRL, 32'h8);
		rdr(A_WDCNT);
		check(rd < 32'h4, 1'b1);
		// without the restart the count would have expired by now
		repeat (WDT - 20) @(posedge i_core_clk);
		#1;
		check(o_failed, 1'b0);
	endtask

	task automatic t_cal();
		rst();
		wr(A_CAL_IN, {CAL_TAG, 8'h0, 16'h1234});
		rdr(A_STAT);
		check(rd[7], 1'b1);
		rst();
		wr(A_CTRL, 32'h3);
		i_keylock <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		wr(A_CAL_IN, {CAL_TAG, 8'h0, 16'h1234});
		rdr(A_THR0);
		check(rd[15:0], RST_THR_APM);
		rdr(A_STAT);
		check(rd[7:6], 2'h1);
		wr(A_CAL_ACC, 32'h0);
		rdr(A_THR0);
		check(rd[15:0], 16'h1234);
		wr(A_CAL_IN, {8'hc4, 8'h0, 16'h5678});
		rdr(A_STAT);
		check(rd[7], 1'b1);
		rdr(8'h3c);
		check(rd, 32'h0);
		i_keylock <= 1'b0;
	endtask

	initial begin
		rst();
		rdr(A_THR0 + 8'h4);
		check(rd[15:0], RST_THR_OSC);
		rdr(A_THR0 + 8'h8);
		check(rd[15:0], RST_THR_SRM);
		t_passes();
		t_link_err();
		t_stall();
		t_kick();
		t_cal();
		end_sim();
	end
endmodule
